// file: inc/asq_pkg.sv
// Constants and types shared by the scan-mode sequencer files
package asq_pkg;
   // ----------------------------------------
   // Register map, byte addresses
   // ----------------------------------------
   localparam logic [4:0] ADR_MODE  = 5'h00;
   localparam logic [4:0] ADR_CUST0 = 5'h04;
   localparam logic [4:0] ADR_CUST1 = 5'h08;
   localparam logic [4:0] ADR_CFG   = 5'h0c;
   localparam logic [4:0] ADR_SLEN  = 5'h10;
   localparam logic [4:0] ADR_SDATA = 5'h14;
   localparam logic [4:0] ADR_CTRL  = 5'h18;
   localparam logic [4:0] ADR_STAT  = 5'h1c;
   // ----------------------------------------
   // Mode word, configuration and control register fields
   // ----------------------------------------
   localparam int MW_SEL   = 15;
   localparam int SC_HI    = 14;
   localparam int SC_LO    = 11;
   localparam int CS_HI    = 10;
   localparam int CS_LO    = 7;
   localparam logic [6:0] MW_LOW_KEEP = 7'h7a;
   localparam int CFG_AVG  = 0;
   localparam int CFG_16CH = 1;
   localparam int CTRL_GO  = 0;
   // ----------------------------------------
   // Scan codes, top channel numbers and sequence list limits
   // ----------------------------------------
   localparam logic [3:0] SC_NULL    = 4'h0;
   localparam logic [3:0] SC_MANUAL  = 4'h1;
   localparam logic [3:0] SC_STD_EXT = 4'h4;
   localparam logic [3:0] SC_UP_INT  = 4'h5;
   localparam logic [3:0] SC_UP_EXT  = 4'h6;
   localparam logic [3:0] SC_CUS_INT = 4'h7;
   localparam logic [3:0] SC_CUS_EXT = 4'h8;
   localparam logic [3:0] SC_USER    = 4'h9;
   localparam logic [3:0] SC_LAST    = 4'h9;
   localparam logic [3:0] CH_TOP16   = 4'hf;
   localparam logic [3:0] CH_TOP8    = 4'h7;
   localparam logic [8:0] SEQ_MAX    = 9'h100;
   localparam logic [8:0] SEQ_MIN    = 9'h001;
   localparam int         SEQ_DEPTH  = 256;

   typedef struct packed {
      logic       ext_clk;
      logic       avg_ok;
      logic       custom;
      logic       user;
      logic       ranged;
      logic [3:0] first;
      logic [3:0] last;
   } asq_plan_t;
endpackage

// file: hdl/asq_mode_decode.sv
// Scan code decoder: turns mode word fields into a scan plan
`timescale 1ns/1ps
module asq_mode_decode
   import asq_pkg::*;
(
   input  wire logic       [3:0] scan_code_i,
   input  wire logic       [3:0] channel_select_code_i,
   input  wire logic             sixteen_ch_i,
   output asq_pkg::asq_plan_t    plan_o
);
   import asq_pkg::*;

   logic [3:0] top_ch;

   assign top_ch = sixteen_ch_i ? CH_TOP16 : CH_TOP8;

   always_comb begin
      plan_o = '0;
      unique case (scan_code_i)
         SC_STD_EXT: begin
            plan_o.ext_clk = 1'b1;                          // [RULE_01]
            plan_o.ranged  = 1'b1;
            plan_o.first   = 4'h0;
            plan_o.last    = channel_select_code_i;          // [RULE_02]
         end
         SC_UP_INT: begin
            plan_o.avg_ok  = 1'b1;                          // [RULE_03]
            plan_o.ranged  = 1'b1;
            plan_o.first   = channel_select_code_i;          // [RULE_02]
            plan_o.last    = top_ch;
         end
         SC_UP_EXT: begin
            plan_o.ext_clk = 1'b1;                          // [RULE_04]
            plan_o.ranged  = 1'b1;
            plan_o.first   = channel_select_code_i;
            plan_o.last    = top_ch;
         end
         SC_CUS_INT: begin
            plan_o.avg_ok  = 1'b1;                          // [RULE_05]
            plan_o.custom  = 1'b1;                          // [RULE_07]
         end
         SC_CUS_EXT: begin
            plan_o.ext_clk = 1'b1;                          // [RULE_06]
            plan_o.custom  = 1'b1;
         end
         SC_USER: begin
            plan_o.ext_clk = 1'b1;                          // [RULE_08]
            plan_o.user    = 1'b1;
         end
         // Manual, repeat and internal standard scans get an empty plan, so no scan starts
         default: plan_o = '0;
      endcase
   end
endmodule

// file: hdl/asq_sequencer.sv
// Scan-mode sequencer top: Avalon-MM registers, mode hold and channel stepping
//
// The implementer's own choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
// Contract
// RULE_01 - External standard scan converts channels zero up to N ascending, no averaging.
// RULE_02 - Standard and upper scans take boundary N from the channel select code.
// RULE_03 - Internal upper scan converts N to top, storing 16-N or 8-N results.
// RULE_04 - External upper scan converts N through top ascending, averaging unavailable.
// RULE_05 - Internal custom scan converts unique ascending channels, at most 16, may average.
// RULE_06 - External custom scan converts unique ascending channels, at most 16, no averaging.
// RULE_07 - Custom scans pick channels from two enable registers, not the select code.
// RULE_08 - User sequence steps up to 256 listed channels, external clock, no averaging.
// RULE_09 - Scan codes 1010 to 1111 keep the current mode and ignore bits 10:0.
// RULE_10 - Channel select code is a plain binary index, zero to fifteen.
// RULE_11 - Scan code 0000 keeps the mode; other low mode bits stay writable.
// RULE_12 - Mode and boundary channel update only on a non-null accepted mode word.
module asq_sequencer
   import asq_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [4:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,
   input  wire logic        conv_done_i,
   output logic      [3:0]  mux_sel_o,
   output logic             conv_start_o,
   output logic             result_store_o,
   output logic             ext_clk_sel_o,
   output logic             avg_en_o,
   output logic             scan_busy_o
);
   import asq_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_WAIT} asq_state_t;

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic        wait_reg;
   logic [31:0] rdata_reg;
   logic [3:0]  scan_code_reg;
   logic [3:0]  channel_select_code_reg;
   logic [6:0]  mode_low_reg;
   logic [7:0]  cust0_reg;
   logic [7:0]  cust1_reg;
   logic        cfg_avg_reg;
   logic        cfg_16ch_reg;
   logic [8:0]  seq_len_reg;
   logic [7:0]  seq_wptr_reg;
   logic [3:0]  seq_mem [SEQ_DEPTH];
   logic        go_req_reg;
   asq_state_t  state_reg;
   asq_plan_t   plan_reg;
   logic [3:0]  mux_sel_reg;
   logic        conv_start_reg;
   logic        store_reg;
   logic        ext_clk_reg;
   logic        avg_reg;
   logic        busy_reg;
   logic [8:0]  cnt_reg;
   logic [7:0]  seq_idx_reg;

   logic        acc;
   logic        wr_acc;
   logic        low_lanes;
   logic [3:0]  code_in;
   logic        mode_wr;
   logic [15:0] cust_mask;
   asq_plan_t   plan_now;
   logic [4:0]  first_en;
   logic [4:0]  next_en;
   logic [8:0]  seq_len_next;
   logic        start_ok;
   logic [3:0]  start_ch;
   logic        more;
   logic [3:0]  next_ch;

   // Lowest enabled channel at or above 'from'; bit 4 set means none left
   function automatic logic [4:0] find_en(input logic [15:0] mask, input logic [4:0] from);
      logic [4:0] res;
      res = 5'h10;
      for (int i = 15; i >= 0; i--) begin
         if (mask[i] && (5'(i) >= from)) begin
            res = 5'(i);
         end
      end
      return res;
   endfunction

   // ----------------------------------------
   // Avalon-MM slave
   // ----------------------------------------
   // Every access waits exactly one cycle so read data comes from a register
   assign acc       = (avs_read_i || avs_write_i) && wait_reg;
   assign wr_acc    = avs_write_i && !wait_reg;
   assign low_lanes = &avs_byteenable_i[1:0];

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         wait_reg <= 1'b1;
      end else begin
         wait_reg <= !acc;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rdata_reg <= 32'h0000_0000;
      end else if (avs_read_i && wait_reg) begin
         unique case (avs_address_i)
            ADR_MODE:  rdata_reg <= {16'h0000, 1'b0, scan_code_reg,
                                     channel_select_code_reg, mode_low_reg};
            ADR_CUST0: rdata_reg <= {24'h00_0000, cust0_reg};
            ADR_CUST1: rdata_reg <= {24'h00_0000, cust1_reg};
            ADR_CFG:   rdata_reg <= {30'h0000_0000, cfg_16ch_reg, cfg_avg_reg};
            ADR_SLEN:  rdata_reg <= {23'h00_0000, seq_len_reg};
            ADR_SDATA: rdata_reg <= {24'h00_0000, seq_wptr_reg};
            ADR_STAT:  rdata_reg <= {12'h000, cnt_reg, 4'h0, ext_clk_reg,
                                     avg_reg, busy_reg, mux_sel_reg};
            default:   rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   assign avs_waitrequest_o = wait_reg;
   assign avs_readdata_o    = rdata_reg;

   // ----------------------------------------
   // Mode word
   // ----------------------------------------
   assign code_in = avs_writedata_i[SC_HI:SC_LO];
   assign mode_wr = wr_acc && low_lanes && (avs_address_i == ADR_MODE)
                    && !avs_writedata_i[MW_SEL];

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         scan_code_reg           <= SC_MANUAL;
         channel_select_code_reg <= 4'h0;
      end else if (mode_wr && (code_in != SC_NULL) && (code_in <= SC_LAST)) begin
         scan_code_reg           <= code_in;                             // [RULE_12]
         channel_select_code_reg <= avs_writedata_i[CS_HI:CS_LO];        // [RULE_10]
      end
   end

   // Null codes leave bits 10:0 alone, except the always-writable group
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         mode_low_reg <= 7'h00;
      end else if (mode_wr) begin
         if (code_in == SC_NULL) begin
            mode_low_reg <= (mode_low_reg & ~MW_LOW_KEEP)
                            | (avs_writedata_i[6:0] & MW_LOW_KEEP);      // [RULE_11]
         end else if (code_in <= SC_LAST) begin
            mode_low_reg <= avs_writedata_i[6:0];                        // [RULE_09]
         end
      end
   end

   // ----------------------------------------
   // Configuration, custom enables, sequence list
   // ----------------------------------------
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         cust0_reg    <= 8'h00;
         cust1_reg    <= 8'h00;
         cfg_avg_reg  <= 1'b0;
         cfg_16ch_reg <= 1'b1;
      end else if (wr_acc && low_lanes) begin
         if (avs_address_i == ADR_CUST0) begin
            cust0_reg <= avs_writedata_i[7:0];
         end
         if (avs_address_i == ADR_CUST1) begin
            cust1_reg <= avs_writedata_i[7:0];
         end
         if (avs_address_i == ADR_CFG) begin
            cfg_avg_reg  <= avs_writedata_i[CFG_AVG];
            cfg_16ch_reg <= avs_writedata_i[CFG_16CH];
         end
      end
   end

   assign cust_mask = {cust1_reg, cust0_reg};

   always_comb begin
      seq_len_next = avs_writedata_i[8:0];
      if (avs_writedata_i[8:0] == 9'h000) begin
         seq_len_next = SEQ_MIN;
      end else if (avs_writedata_i[8:0] > SEQ_MAX) begin
         seq_len_next = SEQ_MAX;
      end
   end

   // Writing the length rewinds the load pointer; each data write appends one entry
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         seq_len_reg  <= SEQ_MIN;
         seq_wptr_reg <= 8'h00;
      end else if (wr_acc && low_lanes && (avs_address_i == ADR_SLEN)) begin
         seq_len_reg  <= seq_len_next;
         seq_wptr_reg <= 8'h00;
      end else if (wr_acc && low_lanes && (avs_address_i == ADR_SDATA)) begin
         seq_wptr_reg <= seq_wptr_reg + 8'h01;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (wr_acc && low_lanes && (avs_address_i == ADR_SDATA)) begin
         seq_mem[seq_wptr_reg] <= avs_writedata_i[3:0];                  // [RULE_08]
      end
   end

   // A start request waits in this flag until the sequencer is idle
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         go_req_reg <= 1'b0;
      end else if (wr_acc && (avs_address_i == ADR_CTRL)
                   && avs_writedata_i[CTRL_GO]) begin
         go_req_reg <= 1'b1;
      end else if (state_reg == ST_IDLE) begin
         go_req_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // Channel stepping
   // ----------------------------------------
   asq_mode_decode u_decode (
      .scan_code_i           (scan_code_reg),
      .channel_select_code_i (channel_select_code_reg),
      .sixteen_ch_i          (cfg_16ch_reg),
      .plan_o                (plan_now)
   );

   assign first_en = find_en(cust_mask, 5'h00);
   assign next_en  = find_en(cust_mask, {1'b0, mux_sel_reg} + 5'h01);

   always_comb begin
      start_ok = 1'b0;
      start_ch = plan_now.first;
      if (plan_now.ranged) begin
         start_ok = (plan_now.first <= plan_now.last);                   // [RULE_03]
      end else if (plan_now.custom) begin
         start_ok = !first_en[4];                                        // [RULE_07]
         start_ch = first_en[3:0];
      end else if (plan_now.user) begin
         start_ok = 1'b1;
         start_ch = seq_mem[0];
      end
   end

   always_comb begin
      more    = 1'b0;
      next_ch = mux_sel_reg + 4'h1;
      if (plan_reg.ranged) begin
         more = (mux_sel_reg != plan_reg.last);                          // [RULE_04]
      end else if (plan_reg.custom) begin
         more    = !next_en[4];                                          // [RULE_06]
         next_ch = next_en[3:0];
      end else if (plan_reg.user) begin
         more    = ({1'b0, seq_idx_reg} + 9'h001) < seq_len_reg;         // [RULE_08]
         next_ch = seq_mem[seq_idx_reg + 8'h01];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         state_reg      <= ST_IDLE;
         plan_reg       <= '0;
         mux_sel_reg    <= 4'h0;
         conv_start_reg <= 1'b0;
         store_reg      <= 1'b0;
         busy_reg       <= 1'b0;
         cnt_reg        <= 9'h000;
         seq_idx_reg    <= 8'h00;
      end else begin
         conv_start_reg <= 1'b0;
         store_reg      <= 1'b0;
         unique case (state_reg)
            ST_IDLE: begin
               if (go_req_reg && start_ok) begin
                  plan_reg    <= plan_now;
                  mux_sel_reg <= start_ch;                               // [RULE_01]
                  cnt_reg     <= 9'h000;
                  seq_idx_reg <= 8'h00;
                  busy_reg    <= 1'b1;
                  state_reg   <= ST_START;
               end
            end
            ST_START: begin
               conv_start_reg <= 1'b1;
               state_reg      <= ST_WAIT;
            end
            ST_WAIT: begin
               if (conv_done_i) begin
                  store_reg <= 1'b1;                                     // [RULE_05]
                  cnt_reg   <= cnt_reg + 9'h001;
                  if (more) begin
                     mux_sel_reg <= next_ch;
                     seq_idx_reg <= seq_idx_reg + 8'h01;
                     state_reg   <= ST_START;
                  end else begin
                     busy_reg  <= 1'b0;
                     state_reg <= ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Clock source and averaging follow the scan in progress; when idle the clock follows the held mode and averaging is off
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         ext_clk_reg <= 1'b0;
         avg_reg     <= 1'b0;
      end else if (busy_reg) begin
         ext_clk_reg <= plan_reg.ext_clk;
         avg_reg     <= cfg_avg_reg && plan_reg.avg_ok;                  // [RULE_04]
      end else begin
         ext_clk_reg <= plan_now.ext_clk || (scan_code_reg == SC_MANUAL);
         avg_reg     <= 1'b0;
      end
   end

   assign mux_sel_o      = mux_sel_reg;
   assign conv_start_o   = conv_start_reg;
   assign result_store_o = store_reg;
   assign ext_clk_sel_o  = ext_clk_reg;
   assign avg_en_o       = avg_reg;
   assign scan_busy_o    = busy_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [3:0] prev_sel_reg;

   always_ff @(posedge ref_clk_i) begin
      if (conv_start_reg) begin
         prev_sel_reg <= mux_sel_reg;
      end
   end

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   chk_null_high_keeps: assert property ( // [RULE_09]
      mode_wr && (code_in > SC_LAST) |=> $stable(scan_code_reg)
         && $stable(channel_select_code_reg) && $stable(mode_low_reg))
      else $error("reserved scan code changed the mode");

   chk_null_zero_keeps: assert property ( // [RULE_11]
      mode_wr && (code_in == SC_NULL) |=> $stable(scan_code_reg)
         && $stable(channel_select_code_reg))
      else $error("null scan code changed the mode");

   chk_mode_loads: assert property ( // [RULE_12]
      mode_wr && (code_in != SC_NULL) && (code_in <= SC_LAST)
      |=> (scan_code_reg == $past(code_in)))
      else $error("valid mode word not held");

   chk_channel_index: assert property ( // [RULE_10]
      mode_wr && (code_in != SC_NULL) && (code_in <= SC_LAST)
      |=> (channel_select_code_reg == $past(avs_writedata_i[CS_HI:CS_LO])))
      else $error("channel select code not held as written");

   chk_std_from_zero: assert property ( // [RULE_01]
      (state_reg == ST_IDLE) && go_req_reg && start_ok && (scan_code_reg == SC_STD_EXT)
      |=> (mux_sel_reg == 4'h0) ##1 conv_start_reg)
      else $error("standard scan did not begin at channel zero");

   chk_upper_count: assert property ( // [RULE_03]
      $fell(busy_reg) && plan_reg.ranged
      |-> (cnt_reg == ({5'h00, plan_reg.last} - {5'h00, plan_reg.first} + 9'h001)))
      else $error("ranged scan stored a wrong result count");

   chk_ascending: assert property ( // [RULE_06]
      conv_start_reg && !plan_reg.user && (cnt_reg != 9'h000)
      |-> (mux_sel_reg > prev_sel_reg))
      else $error("channel order not ascending");

   chk_custom_enabled: assert property ( // [RULE_07]
      conv_start_reg && plan_reg.custom |-> cust_mask[mux_sel_reg] && (cnt_reg < 9'h010))
      else $error("custom scan hit a disabled channel");

   chk_ext_no_avg: assert property ( // [RULE_08]
      busy_reg && plan_reg.ext_clk |=> !avg_reg)
      else $error("averaging on in an external clock scan");

   chk_bus_answer: assert property (
      (avs_read_i || avs_write_i) && wait_reg |=> !wait_reg ##1 wait_reg)
      else $error("bus answer not one cycle long");
endmodule

// file: test/asq_conv_model.sv
// Behavioural converter core that answers each conversion start with a done pulse
`timescale 1ns/1ps
module asq_conv_model (
   input  wire logic ref_clk_i,
   input  wire logic sys_rst_i,
   input  wire logic conv_start_i,
   input  wire logic slow_i,
   output logic      conv_done_o
);
   int unsigned wait_cnt;
   logic        busy;

   initial begin
      conv_done_o = 1'b0;
      busy        = 1'b0;
      wait_cnt    = 0;
   end

   // Slow mode varies the conversion time, so no fixed latency can be relied on
   always @(posedge ref_clk_i) begin
      conv_done_o <= 1'b0;
      if (sys_rst_i) begin
         busy <= 1'b0;
      end else if (conv_start_i === 1'b1) begin
         busy     <= 1'b1;
         wait_cnt <= slow_i ? 2 + ($urandom % 12) : 0;
      end else if (busy) begin
         if (wait_cnt == 0) begin
            busy        <= 1'b0;
            conv_done_o <= 1'b1;
         end else begin
            wait_cnt <= wait_cnt - 1;
         end
      end
   end
endmodule

// file: test/testbench.sv
// Self-checking bench for the scan-mode sequencer
`timescale 1ns/1ps
module testbench;
   import asq_pkg::*;
   logic        ref_clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic [4:0]  avs_address_i = 5'h00;
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0000_0000;
   logic [3:0]  avs_byteenable_i = 4'hf;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic        conv_done_i;
   logic [3:0]  mux_sel_o;
   logic        conv_start_o, result_store_o, ext_clk_sel_o, avg_en_o, scan_busy_o;
   logic        slow = 1'b0;
   logic [5:0]  exp_q[$];
   logic [3:0]  ulist[$];
   int          n_fail = 0, n_compared = 0, n_store = 0, cyc = 0;

   asq_sequencer dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .conv_done_i(conv_done_i), .mux_sel_o(mux_sel_o), .conv_start_o(conv_start_o),
      .result_store_o(result_store_o), .ext_clk_sel_o(ext_clk_sel_o),
      .avg_en_o(avg_en_o), .scan_busy_o(scan_busy_o));
   asq_conv_model conv (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
      .conv_start_i(conv_start_o), .slow_i(slow), .conv_done_o(conv_done_i));

   always #10 ref_clk_i = ~ref_clk_i;

   // ----------------------------------------
   // Reporting and scoreboard
   // ----------------------------------------
   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   always @(posedge ref_clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         n_fail++;
         finish_test();
      end
      if (result_store_o === 1'b1) n_store++;
      if (conv_start_o === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_fail++;
            $display("MISMATCH %0t unexpected conversion start", $time);
         end else begin
            cmp({ext_clk_sel_o, avg_en_o, mux_sel_o}, exp_q.pop_front(), "channel");
         end
      end
   end

   // ----------------------------------------
   // Bus and scan tasks
   // ----------------------------------------
   task automatic bus(input logic is_rd, input logic [4:0] a, input logic [31:0] wd,
                      output logic [31:0] q);
      @(posedge ref_clk_i);
      avs_address_i   <= a;
      avs_writedata_i <= wd;
      avs_read_i      <= is_rd;
      avs_write_i     <= !is_rd;
      do begin
         @(posedge ref_clk_i);
      end while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
   endtask

   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b0, a, d, q);
   endtask

   task automatic setup(input logic [3:0] code, input logic [3:0] ch, input logic [15:0] m,
                        input logic [1:0] cf);
      wr(ADR_CFG, {30'h0, cf});
      wr(ADR_CUST0, {24'h0, m[7:0]});
      wr(ADR_CUST1, {24'h0, m[15:8]});
      wr(ADR_MODE, {16'h0, 1'b0, code, ch, 7'h00});
   endtask

   // Expected channel list is built from the mode plan before the start is issued
   task automatic go(input logic [3:0] code, input logic [3:0] ch, input logic [15:0] m,
                     input logic [1:0] cf);
      logic        ext, avg;
      logic [3:0]  top;
      logic [31:0] q;
      int          cnt, t;
      ext = !(code == SC_UP_INT || code == SC_CUS_INT);
      avg = !ext && cf[CFG_AVG];
      top = cf[CFG_16CH] ? CH_TOP16 : CH_TOP8;
      for (int c = 0; c < 16; c++) begin
         if ((code == SC_STD_EXT && c <= ch) ||
             (code inside {SC_UP_INT, SC_UP_EXT} && c >= ch && c <= top && ch <= top) ||
             (code inside {SC_CUS_INT, SC_CUS_EXT} && m[c])) begin
            exp_q.push_back({ext, avg, 4'(c)});
         end
      end
      if (code == SC_USER) begin
         foreach (ulist[i]) exp_q.push_back({2'b10, ulist[i]});
      end
      cnt = exp_q.size();
      n_store = 0;
      t = 0;
      wr(ADR_CTRL, 32'h0000_0001);
      while (scan_busy_o !== 1'b1 && t < 8) begin
         @(posedge ref_clk_i);
         t++;
      end
      while (scan_busy_o === 1'b1) begin
         @(posedge ref_clk_i);
         t++;
      end
      repeat (2) @(posedge ref_clk_i);
      cmp(n_store, cnt, "results stored");
      cmp(exp_q.size(), 0, "channels left over");
      exp_q.delete();
      if (cnt > 0) begin
         bus(1'b1, ADR_STAT, 32'h0, q);
         cmp(q[19:11], cnt, "status count");
      end
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] q;
      logic [3:0]  ch, code;
      logic [15:0] m;
      logic [1:0]  cf;
      void'($urandom(32'hb86b_ae9f));
      repeat (2) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      bus(1'b1, ADR_STAT, 32'h0, q);
      cmp(q, 32'h0000_0040, "reset status");
      go(SC_MANUAL, 4'h0, 16'h0, 2'b10);
      for (int n = 0; n < 16; n++) begin
         setup(SC_STD_EXT, 4'(n), 16'h0, 2'b10);
         go(SC_STD_EXT, 4'(n), 16'h0, 2'b10);
      end
      for (int i = 0; i < 6; i++) begin
         ch = 4'($urandom);
         m = (i == 0) ? 16'hffff : 16'($urandom);
         cf = {1'($urandom), 1'($urandom)};
         slow <= 1'($urandom);
         for (int k = 0; k < 4; k++) begin
            code = 4'(SC_UP_INT + k);
            setup(code, ch, m, cf);
            go(code, ch, m, cf);
         end
      end
      setup(SC_STD_EXT, 4'h3, 16'h0, 2'b10);
      for (int k = 0; k < 7; k++) begin
         code = (k == 6) ? SC_NULL : 4'(10 + k);
         wr(ADR_MODE, {16'h0, 1'b0, code, 4'hc, 7'h7f});
         go(SC_STD_EXT, 4'h3, 16'h0, 2'b10);
      end
      bus(1'b1, ADR_MODE, 32'h0, q);
      cmp(q, 32'h0000_21fa, "mode word");
      wr(ADR_MODE, {16'h0, 1'b1, SC_UP_EXT, 4'h1, 7'h00});
      avs_byteenable_i <= 4'hc;
      wr(ADR_MODE, {16'h0, 1'b0, SC_UP_EXT, 4'h1, 7'h00});
      avs_byteenable_i <= 4'hf;
      bus(1'b1, ADR_MODE, 32'h0, q);
      cmp(q, 32'h0000_21fa, "mode word kept");
      go(SC_STD_EXT, 4'h3, 16'h0, 2'b10);
      for (int j = 0; j < 2; j++) begin
         ulist.delete();
         wr(ADR_SLEN, (j == 0) ? 32'h0000_0003 : 32'h0000_0100);
         for (int i = 0; i < ((j == 0) ? 3 : 256); i++) begin
            ulist.push_back(4'($urandom));
            wr(ADR_SDATA, {28'h0, ulist[i]});
         end
         setup(SC_USER, 4'h0, 16'h0, 2'b11);
         go(SC_USER, 4'h0, 16'h0, 2'b11);
      end
      finish_test();
   end
endmodule
